//--- mtc_pkg.sv
/*
 * mtc_pkg: constants, types and reset values shared by the MAC control
 * block and its deferral timer.
 * Assumes one 40 MHz clock and a bit time of the 10 Mb/s line.
 */
package mtc_pkg;

   // clock and line timing
   localparam int CLK_PERIOD_NS    = 25;
   localparam int BIT_TIME_NS      = 100;
   localparam int BIT_CYCLES       = (BIT_TIME_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
   localparam int DEFER_LIMIT_BITS = 24288;
   localparam int SLOT_BITS        = 512;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL     = 6'h01;
   localparam logic [5:0] IDX_STA_HIGH = 6'h02;
   localparam logic [5:0] IDX_IRQ_STAT = 6'h08;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h09;

   // control register fields
   localparam int CTRL_BOSEL_LSB = 6;
   localparam int CTRL_DCHK_BIT  = 5;
   localparam int CTRL_TX_EN_BIT = 3;
   localparam int CTRL_RX_EN_BIT = 2;

   // interrupt status bits
   localparam int IRQ_ABORT_BIT  = 0;
   localparam int IRQ_TXDONE_BIT = 1;
   localparam int IRQ_EEDONE_BIT = 2;

   // back-off limit encodings and bit counts
   localparam logic [1:0] BOSEL_10 = 2'h0;
   localparam logic [1:0] BOSEL_8  = 2'h1;
   localparam logic [1:0] BOSEL_4  = 2'h2;
   localparam logic [1:0] BOSEL_1  = 2'h3;
   localparam logic [3:0] KMAX     = 4'ha;

   // eeprom locations of the upper address bytes
   localparam logic [7:0] EE_LOC_LO = 8'h05;
   localparam logic [7:0] EE_LOC_HI = 8'h06;

   localparam logic [15:0] STA_HIGH_RST = 16'hffff;

   typedef enum logic [1:0] {ST_IDLE, ST_DEFER, ST_XMIT, ST_BACKOFF}
      mtc_state_e;
   typedef enum logic [1:0] {EE_START, EE_LO, EE_HI, EE_DONE} mtc_ee_e;

   typedef struct packed {
      mtc_state_e  st;
      mtc_ee_e     ee;
      logic        dchk;
      logic        tx_en;
      logic        rx_en;
      logic [1:0]  bosel;
      logic [15:0] sta;
      logic [2:0]  ist;
      logic [2:0]  imsk;
      logic [31:0] rdata;
      logic        ee_req;
      logic [7:0]  ee_addr;
      logic [19:0] lfsr;
      logic [3:0]  retry;
      logic [9:0]  slots;
      logic [8:0]  sbits;
      logic        start;
      logic        abort;
   } mtc_main_s;

   localparam mtc_main_s MAIN_RST = '{
      st: ST_IDLE, ee: EE_START, dchk: 1'b0, tx_en: 1'b0, rx_en: 1'b0,
      bosel: 2'h0, sta: STA_HIGH_RST, ist: 3'h0, imsk: 3'h0,
      rdata: 32'h0000_0000, ee_req: 1'b0, ee_addr: 8'h00,
      lfsr: 20'h0_0001, retry: 4'h0, slots: 10'h000, sbits: 9'h000,
      start: 1'b0, abort: 1'b0};

endpackage

//--- mtc_defer_if.sv
/*
 * mtc_defer_if: carrier between the control logic and the deferral timer.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/1ps
interface mtc_defer_if;
   logic bit_tick;
   logic run;
   logic clear;
   logic expired;

   modport timer (output bit_tick, output expired, input run, input clear);
   modport ctrl  (input bit_tick, input expired, output run, output clear);
endinterface

//--- mtc_defer_timer.sv
/*
 * mtc_defer_timer: bit-time divider and deferral counter.
 * Assumes run and clear come from the control logic on ref_clk.
 */
`timescale 1ns/1ps
module mtc_defer_timer
   import mtc_pkg::*;
#(
   parameter int LIMIT_BITS = DEFER_LIMIT_BITS
)(
   input  wire logic        ref_clk,  // system clock
   input  wire logic        sys_rst,  // async reset, high
   mtc_defer_if.timer       dif       // to control logic
);
   localparam int CW = $clog2(LIMIT_BITS + 2);
   localparam int DW = $clog2(BIT_CYCLES + 1);

   typedef struct packed {
      logic [DW-1:0] div;
      logic [CW-1:0] cnt;
      logic          tick;
      logic          expired;
   } mtc_tmr_s;

   mtc_tmr_s s_r;
   mtc_tmr_s s_nxt;

   assign dif.bit_tick = s_r.tick;
   assign dif.expired  = s_r.expired;

   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.div == DW'(BIT_CYCLES - 1))
      begin
         s_nxt.div  = '0;
         s_nxt.tick = 1'b1;
      end
      else
         s_nxt.div = s_r.div + 1'b1;
      // held at zero outside a deferral so each period starts fresh
      if (dif.clear)
         s_nxt.cnt = '0;
      else if (dif.run && s_r.tick && !s_r.expired)
         s_nxt.cnt = s_r.cnt + 1'b1;
      s_nxt.expired = (s_nxt.cnt > CW'(LIMIT_BITS));
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   property p_tmr_clear;
      @(posedge ref_clk) disable iff (sys_rst)
      dif.clear |=> (s_r.cnt == '0) && !dif.expired;
   endproperty
   a_tmr_clear: assert property (p_tmr_clear)
      else $error("deferral count not cleared");

   property p_tmr_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      !dif.run && !dif.clear |=> $stable(s_r.cnt);
   endproperty
   a_tmr_hold: assert property (p_tmr_hold)
      else $error("deferral count moved without carrier hold-off");
endmodule

//--- mtc_mac_ctrl.sv
/*
 * mtc_mac_ctrl: transmit and receive enables, deferral abort, back-off
 * slot selection, upper station address with eeprom preload, interrupts.
 * Assumes a register port with read data one cycle after the read strobe,
 * single-cycle pulses for collision, done and eeprom data valid.
 */
`timescale 1ns/1ps
module mtc_mac_ctrl
   import mtc_pkg::*;
#(
   parameter int LIMIT_BITS = DEFER_LIMIT_BITS
)(
   input  wire logic        ref_clk,        // system clock
   input  wire logic        sys_rst,        // async reset, high
   input  wire logic [7:0]  reg_addr,       // register byte address
   input  wire logic [31:0] reg_wdata,      // register write data
   input  wire logic        reg_wr,         // write strobe
   input  wire logic        reg_rd,         // read strobe
   output logic      [31:0] reg_rdata,      // read data, next cycle
   output logic             irq,            // interrupt level
   input  wire logic        tx_frame_ready, // buffer holds a frame
   input  wire logic        crs,            // carrier sense
   input  wire logic        tx_collision,   // collision pulse
   input  wire logic        tx_done,        // frame sent pulse
   output logic             tx_start,       // start frame pulse
   output logic             tx_abort,       // deferral abort pulse
   output logic             tx_deferring,   // waiting on carrier
   input  wire logic        rx_frame_valid, // phy offers a frame
   output logic             rx_accept,      // frame taken
   input  wire logic        ee_present,     // programmed eeprom found
   output logic             ee_req,         // eeprom byte request
   output logic      [7:0]  ee_addr,        // eeprom location
   input  wire logic        ee_valid,       // eeprom byte pulse
   input  wire logic [7:0]  ee_data,        // eeprom byte
   output logic             init_done       // preload finished
);
   mtc_main_s   s_r;
   mtc_main_s   s_nxt;
   mtc_defer_if dif ();

   mtc_defer_timer #(
      .LIMIT_BITS (LIMIT_BITS)
   ) u_timer (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .dif     (dif)
   );

   // slot count mask from retry count and limit field
   function automatic logic [9:0] bo_mask(input logic [3:0] n,
                                          input logic [1:0] sel);
      logic [3:0] k;
      logic [3:0] lim;
      k = (n > KMAX) ? KMAX : n;
      unique case (sel)
         BOSEL_10: lim = 4'ha;
         BOSEL_8:  lim = 4'h8;
         BOSEL_4:  lim = 4'h4;
         BOSEL_1:  lim = 4'h1;
      endcase
      if (lim < k)
         k = lim;
      bo_mask = 10'((11'h001 << k) - 11'h001);
   endfunction

   logic       sel_ctrl;
   logic       sel_sta;
   logic       sel_ist;
   logic       sel_imsk;
   logic [2:0] ev;
   logic [3:0] retry_inc;

   always_comb
   begin
      sel_ctrl = (reg_addr == {IDX_CTRL, 2'b00});
      sel_sta  = (reg_addr == {IDX_STA_HIGH, 2'b00});
      sel_ist  = (reg_addr == {IDX_IRQ_STAT, 2'b00});
      sel_imsk = (reg_addr == {IDX_IRQ_MASK, 2'b00});
   end

   assign retry_inc = (s_r.retry == 4'hf) ? s_r.retry : s_r.retry + 4'h1;

   // deferral is timed only while carrier holds off a ready frame
   assign dif.run   = (s_r.st == ST_DEFER) && crs;
   assign dif.clear = (s_r.st != ST_DEFER);

   always_comb
   begin
      s_nxt       = s_r;
      ev          = 3'h0;
      s_nxt.start = 1'b0;
      s_nxt.abort = 1'b0;
      s_nxt.lfsr  = {s_r.lfsr[18:0], s_r.lfsr[19] ^ s_r.lfsr[16]};

      unique case (s_r.st)
         ST_IDLE:
            if (s_r.tx_en && tx_frame_ready)
               s_nxt.st = ST_DEFER;
         ST_DEFER:
         begin
            if (!s_r.tx_en)
               s_nxt.st = ST_IDLE;
            else if (!crs)
            begin
               s_nxt.start = 1'b1;
               s_nxt.st    = ST_XMIT;
            end
            // with the check off the expiry is simply ignored
            else if (s_r.dchk && dif.expired)
            begin
               s_nxt.abort          = 1'b1;
               s_nxt.retry          = 4'h0;
               ev[IRQ_ABORT_BIT]    = 1'b1;
               s_nxt.st             = ST_IDLE;
            end
         end
         ST_XMIT:
            if (tx_collision)
            begin
               s_nxt.retry = retry_inc;
               s_nxt.slots = s_r.lfsr[9:0] & bo_mask(retry_inc, s_r.bosel);
               s_nxt.sbits = 9'h000;
               s_nxt.st    = ST_BACKOFF;
            end
            else if (tx_done)
            begin
               s_nxt.retry        = 4'h0;
               ev[IRQ_TXDONE_BIT] = 1'b1;
               s_nxt.st           = ST_IDLE;
            end
         ST_BACKOFF:
            if (s_r.slots == 10'h000)
               s_nxt.st = ST_DEFER;
            else if (dif.bit_tick)
            begin
               s_nxt.sbits = s_r.sbits + 9'h001;
               if (s_r.sbits == 9'(SLOT_BITS - 1))
                  s_nxt.slots = s_r.slots - 10'h001;
            end
      endcase

      // upper address preload; ee_present taken after reset release
      unique case (s_r.ee)
         EE_START:
            if (ee_present)
            begin
               s_nxt.ee_req  = 1'b1;
               s_nxt.ee_addr = EE_LOC_LO;
               s_nxt.ee      = EE_LO;
            end
            else
            begin
               ev[IRQ_EEDONE_BIT] = 1'b1;
               s_nxt.ee           = EE_DONE;
            end
         EE_LO:
            if (ee_valid)
            begin
               s_nxt.sta[7:0] = ee_data;
               s_nxt.ee_addr  = EE_LOC_HI;
               s_nxt.ee       = EE_HI;
            end
         EE_HI:
            if (ee_valid)
            begin
               s_nxt.sta[15:8]    = ee_data;
               s_nxt.ee_req       = 1'b0;
               ev[IRQ_EEDONE_BIT] = 1'b1;
               s_nxt.ee           = EE_DONE;
            end
         EE_DONE:
            s_nxt.ee = EE_DONE;
      endcase

      if (reg_wr)
      begin
         if (sel_ctrl)
         begin
            s_nxt.dchk  = reg_wdata[CTRL_DCHK_BIT];
            s_nxt.tx_en = reg_wdata[CTRL_TX_EN_BIT];
            s_nxt.rx_en = reg_wdata[CTRL_RX_EN_BIT];
            s_nxt.bosel = reg_wdata[CTRL_BOSEL_LSB +: 2];
         end
         // only the low half is stored, and only once preload is over
         if (sel_sta && s_r.ee == EE_DONE)
            s_nxt.sta = reg_wdata[15:0];
         if (sel_imsk)
            s_nxt.imsk = reg_wdata[2:0];
      end

      // write-one-to-clear; a new event in the same cycle wins
      s_nxt.ist = s_r.ist & ~((reg_wr && sel_ist) ? reg_wdata[2:0] : 3'h0);
      s_nxt.ist = s_nxt.ist | ev;

      s_nxt.rdata = 32'h0000_0000;
      if (reg_rd)
      begin
         if (sel_ctrl)
         begin
            s_nxt.rdata[CTRL_DCHK_BIT]       = s_r.dchk;
            s_nxt.rdata[CTRL_TX_EN_BIT]      = s_r.tx_en;
            s_nxt.rdata[CTRL_RX_EN_BIT]      = s_r.rx_en;
            s_nxt.rdata[CTRL_BOSEL_LSB +: 2] = s_r.bosel;
         end
         else if (sel_sta)
            s_nxt.rdata = {16'h0000, s_r.sta};
         else if (sel_ist)
            s_nxt.rdata[2:0] = s_r.ist;
         else if (sel_imsk)
            s_nxt.rdata[2:0] = s_r.imsk;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         s_r <= MAIN_RST;
      else
         s_r <= s_nxt;
   end

   assign reg_rdata    = s_r.rdata;
   assign irq          = |(s_r.ist & s_r.imsk);
   assign tx_start     = s_r.start;
   assign tx_abort     = s_r.abort;
   assign tx_deferring = (s_r.st == ST_DEFER);
   assign rx_accept    = s_r.rx_en && rx_frame_valid;
   assign ee_req       = s_r.ee_req;
   assign ee_addr      = s_r.ee_addr;
   assign init_done    = (s_r.ee == EE_DONE);

   property p_abort_cause;
      @(posedge ref_clk) disable iff (sys_rst)
      (s_r.st == ST_DEFER) && s_r.tx_en && crs && s_r.dchk && dif.expired
      |=> tx_abort && (s_r.st == ST_IDLE);
   endproperty
   a_abort_cause: assert property (p_abort_cause)
      else $error("deferral over limit did not abort");

   property p_no_abort_off;
      @(posedge ref_clk) disable iff (sys_rst)
      !s_r.dchk |=> !tx_abort;
   endproperty
   a_no_abort_off: assert property (p_no_abort_off)
      else $error("abort with deferral check disabled");

   property p_run_cause;
      @(posedge ref_clk) disable iff (sys_rst)
      dif.run |-> crs && tx_deferring;
   endproperty
   a_run_cause: assert property (p_run_cause)
      else $error("deferral timer ran without carrier hold-off");

   property p_fresh_defer;
      @(posedge ref_clk) disable iff (sys_rst)
      (s_r.st == ST_BACKOFF) ##1 (s_r.st == ST_DEFER) |-> !dif.expired;
   endproperty
   a_fresh_defer: assert property (p_fresh_defer)
      else $error("deferral time carried across attempts");

   property p_start_en;
      @(posedge ref_clk) disable iff (sys_rst)
      tx_start |-> $past(s_r.tx_en) && $past(!crs);
   endproperty
   a_start_en: assert property (p_start_en)
      else $error("frame started while disabled or carrier busy");

   property p_rx_off;
      @(posedge ref_clk) disable iff (sys_rst)
      reg_wr && sel_ctrl && !reg_wdata[CTRL_RX_EN_BIT] |=> !rx_accept;
   endproperty
   a_rx_off: assert property (p_rx_off)
      else $error("frame accepted with receiver disabled");

   property p_sta_read;
      @(posedge ref_clk) disable iff (sys_rst)
      reg_rd && sel_sta |=> reg_rdata == {16'h0000, $past(s_r.sta)};
   endproperty
   a_sta_read: assert property (p_sta_read)
      else $error("address high read back wrong");

   property p_ee_load;
      @(posedge ref_clk) disable iff (sys_rst)
      ee_valid && (s_r.ee == EE_HI) |=> s_r.sta[15:8] == $past(ee_data)
      && init_done && !ee_req;
   endproperty
   a_ee_load: assert property (p_ee_load)
      else $error("eeprom high byte not loaded");

   property p_wr_early;
      @(posedge ref_clk) disable iff (sys_rst)
      reg_wr && sel_sta && !init_done && !ee_valid |=> $stable(s_r.sta);
   endproperty
   a_wr_early: assert property (p_wr_early)
      else $error("address written before initialisation done");

   property p_rst_val;
      @(posedge ref_clk) disable iff (sys_rst)
      (s_r.ee == EE_START) |-> s_r.sta == STA_HIGH_RST;
   endproperty
   a_rst_val: assert property (p_rst_val)
      else $error("address high reset value wrong");

   property p_bo_bound;
      @(posedge ref_clk) disable iff (sys_rst)
      (s_r.st == ST_XMIT) && tx_collision
      |=> ((s_r.slots >> s_r.retry) == 10'h000)
      && (s_r.bosel != BOSEL_8 || s_r.slots[9:8] == 2'h0)
      && (s_r.bosel != BOSEL_4 || s_r.slots[9:4] == 6'h00)
      && (s_r.bosel != BOSEL_1 || s_r.slots[9:1] == 9'h000);
   endproperty
   a_bo_bound: assert property (p_bo_bound)
      else $error("back-off wait exceeds selected range");

   property p_tx_off;
      @(posedge ref_clk) disable iff (sys_rst)
      !s_r.tx_en |=> !tx_start;
   endproperty
   a_tx_off: assert property (p_tx_off)
      else $error("frame started with transmitter disabled");

   property p_defer_entry;
      @(posedge ref_clk) disable iff (sys_rst)
      (s_r.st == ST_IDLE) && !tx_frame_ready |=> !tx_deferring;
   endproperty
   a_defer_entry: assert property (p_defer_entry)
      else $error("deferral entered with no frame ready");

   property p_abort_flag;
      @(posedge ref_clk) disable iff (sys_rst)
      tx_abort |-> s_r.ist[IRQ_ABORT_BIT];
   endproperty
   a_abort_flag: assert property (p_abort_flag)
      else $error("abort not recorded in status");
endmodule

//--- mtc_phy_model.sv
/*
 * mtc_phy_model: far side of the MAC control block, line and eeprom.
 * Assumes the bench commands carrier, offered frames and collisions.
 */
`timescale 1ns/1ps
module mtc_phy_model
   import mtc_pkg::*;
(
   input  wire logic       ref_clk,        // system clock
   input  wire logic       busy,           // bench: carrier on line
   input  wire logic       rx_on,          // bench: frame offered
   input  wire logic [1:0] coll_n,         // bench: collisions per frame
   input  wire logic       tx_start,       // frame start pulse
   output logic            crs,            // carrier sense
   output logic            rx_frame_valid, // frame offered
   output logic            tx_collision,   // collision pulse
   output logic            tx_done,        // frame sent pulse
   input  wire logic       ee_req,         // byte request
   input  wire logic [7:0] ee_addr,        // byte location
   output logic            ee_valid,       // byte pulse
   output logic      [7:0] ee_data         // byte
);
   int t  = 0;
   int cc = 0;
   int w  = 0;

   assign crs            = busy;
   assign rx_frame_valid = rx_on;

   initial
   begin
      tx_collision = 1'b0;
      tx_done      = 1'b0;
      ee_valid     = 1'b0;
      ee_data      = 8'h00;
   end

   // frame lasts 8 cycles, then collides or completes
   always @(posedge ref_clk)
   begin
      tx_done      <= 1'b0;
      tx_collision <= 1'b0;
      if (tx_start)
         t <= 8;
      else if (t > 0)
         t <= t - 1;
      if (t == 1 && cc < coll_n)
      begin
         tx_collision <= 1'b1;
         cc           <= cc + 1;
      end
      else if (t == 1)
      begin
         tx_done <= 1'b1;
         cc      <= 0;
      end
   end

   // slow eeprom; data wiggles outside a byte so stale values never match
   always @(posedge ref_clk)
   begin
      ee_valid <= 1'b0;
      ee_data  <= ~ee_data;
      if (ee_req && !ee_valid)
      begin
         w <= w + 1;
         if (w == 5)
         begin
            w        <= 0;
            ee_valid <= 1'b1;
            ee_data  <= (ee_addr == EE_LOC_LO) ? 8'ha5 :
                        (ee_addr == EE_LOC_HI) ? 8'h3c : 8'h00;
         end
      end
   end
endmodule

//--- tb_top.sv
/*
 * tb_top: self-checking bench for the MAC control block.
 * Assumes the far-side model and a deferral limit shortened to 20.
 */
`timescale 1ns/1ps
module tb_top;
   import mtc_pkg::*;
   localparam int LIM = 20;
   logic        ref_clk, sys_rst, reg_wr, reg_rd, irq, tx_frame_ready;
   logic [7:0]  reg_addr, ee_addr, ee_data;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic        crs, tx_collision, tx_done, tx_start, tx_abort;
   logic        tx_deferring, rx_frame_valid, rx_accept, ee_present;
   logic        ee_req, ee_valid, init_done, busy, rx_on;
   logic [1:0]  coll_n;
   int          n_fail = 0;
   int          n_tests = 0;
   int          n;
   wire  [3:0]  mon = {init_done, tx_deferring, tx_abort, tx_start};

   mtc_mac_ctrl #(.LIMIT_BITS(LIM)) dut_u (.ref_clk, .sys_rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .tx_frame_ready,
      .crs, .tx_collision, .tx_done, .tx_start, .tx_abort, .tx_deferring,
      .rx_frame_valid, .rx_accept, .ee_present, .ee_req, .ee_addr,
      .ee_valid, .ee_data, .init_done);
   mtc_phy_model phy_u (.ref_clk, .busy, .rx_on, .coll_n, .tx_start, .crs,
      .rx_frame_valid, .tx_collision, .tx_done, .ee_req, .ee_addr,
      .ee_valid, .ee_data);

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(string s, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask

   task automatic range(string s, int lo, int hi, int g);
      n_tests++;
      if (g < lo || g > hi)
      begin
         n_fail++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", s, lo, hi, g);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // every wait is bounded; running out ends the run as a failure
   task automatic wait_on(int k, int lim, output int c);
      c = 0;
      do
      begin
         @(posedge ref_clk);
         #1 c++;
         if (c > lim)
         begin
            n_fail++;
            $display("unexpected timeout: expected event %0d, seen none", k);
            complete_run();
         end
      end
      while (mon[k] !== 1'b1);
   endtask

   task automatic quiet(int k, int cyc, string s);
      repeat (cyc)
      begin
         @(posedge ref_clk);
         #1 check(s, 32'h0000_0000, {31'h0, mon[k]});
      end
   endtask

   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic idle();
      @(posedge ref_clk);
      tx_frame_ready <= 1'b0;
      busy           <= 1'b0;
      repeat (30) @(posedge ref_clk);
      wr(8'h20, 32'h0000_0007);
   endtask

   task automatic do_reset(logic pres);
      @(posedge ref_clk);
      sys_rst    <= 1'b1;
      ee_present <= pres;
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
   endtask

   task automatic t_preload();
      do_reset(1'b1);
      wr(8'h08, 32'h0000_1234);
      rd_reg(8'h08, rd);
      check("station early", 32'h0000_ffff, rd);
      check("init_done early", 32'h0, {31'h0, init_done});
      wait_on(3, 100, n);
      check("eeprom request", 32'h0, {31'h0, ee_req});
      check("eeprom location", {24'h0, EE_LOC_HI}, {24'h0, ee_addr});
      rd_reg(8'h08, rd);
      check("station loaded", 32'h0000_3ca5, rd);
      wr(8'h08, 32'hdead_beef);
      rd_reg(8'h08, rd);
      check("station written", 32'h0000_beef, rd);
      rd_reg(8'h0c, rd);
      check("unmapped read", 32'h0000_0000, rd);
      rd_reg(8'h20, rd);
      check("status load", 32'h0000_0004, rd);
      check("irq masked", 32'h0, {31'h0, irq});
      wr(8'h24, 32'h0000_0004);
      settle();
      check("irq unmasked", 32'h1, {31'h0, irq});
      wr(8'h20, 32'h0000_0004);
      settle();
      check("irq cleared", 32'h0, {31'h0, irq});
      $display("test preload finished");
   endtask

   task automatic t_defaults();
      do_reset(1'b0);
      wait_on(3, 10, n);
      rd_reg(8'h08, rd);
      check("station reset", 32'h0000_ffff, rd);
      rd_reg(8'h04, rd);
      check("control reset", 32'h0000_0000, rd);
      $display("test defaults finished");
   endtask

   task automatic t_transmit_enable();
      wr(8'h04, 32'h0000_0000);
      tx_frame_ready <= 1'b1;
      quiet(0, 30, "start while disabled");
      wr(8'h04, 32'h0000_0008);
      wait_on(0, 12, n);
      repeat (15) @(posedge ref_clk);
      rd_reg(8'h20, rd);
      check("done status", 32'h1, {31'h0, rd[1]});
      idle();
      $display("test transmit enable finished");
   endtask

   task automatic t_rx();
      rx_on <= 1'b1;
      settle();
      check("accept disabled", 32'h0, {31'h0, rx_accept});
      wr(8'h04, 32'h0000_0004);
      settle();
      check("accept enabled", 32'h1, {31'h0, rx_accept});
      wr(8'h04, 32'h0000_0000);
      settle();
      check("accept off again", 32'h0, {31'h0, rx_accept});
      rx_on <= 1'b0;
      $display("test receive enable finished");
   endtask

   task automatic t_abort();
      wr(8'h04, 32'h0000_0028);
      busy <= 1'b1;
      quiet(2, 10, "deferring without frame");
      @(posedge ref_clk);
      tx_frame_ready <= 1'b1;
      wait_on(2, 10, n);
      wait_on(1, 200, n);
      range("abort delay", LIM * 4, LIM * 4 + 12, n);
      rd_reg(8'h20, rd);
      check("abort status", 32'h1, {31'h0, rd[0]});
      idle();
      $display("test deferral abort finished");
   endtask

   task automatic t_nolimit();
      wr(8'h04, 32'h0000_0008);
      busy           <= 1'b1;
      tx_frame_ready <= 1'b1;
      wait_on(2, 10, n);
      quiet(1, LIM * 12, "abort with check off");
      check("still deferring", 32'h1, {31'h0, tx_deferring});
      busy <= 1'b0;
      wait_on(0, 12, n);
      idle();
      $display("test unlimited deferral finished");
   endtask

   task automatic t_restart();
      wr(8'h04, 32'h0000_00e8);
      coll_n         <= 2'd1;
      busy           <= 1'b1;
      tx_frame_ready <= 1'b1;
      wait_on(2, 10, n);
      repeat ((LIM - 4) * 4) @(posedge ref_clk);
      busy <= 1'b0;
      wait_on(0, 12, n);
      busy <= 1'b1;
      wait_on(2, 3000, n);
      wait_on(1, 200, n);
      range("deferral restart", LIM * 4, LIM * 4 + 12, n);
      coll_n <= 2'd0;
      idle();
      $display("test deferral restart finished");
   endtask

   task automatic t_backoff();
      int bits[4] = '{10, 8, 4, 1};
      int mx;
      for (int b = 0; b < 4; b++)
      begin
         wr(8'h04, 32'h0000_0008 | (b << 6));
         mx = (1 << ((bits[b] < 2) ? bits[b] : 2)) - 1;
         coll_n         <= 2'd2;
         tx_frame_ready <= 1'b1;
         wait_on(0, 12, n);
         wait_on(0, 3000, n);
         range("first backoff", 8, 2048 + 30, n);
         wait_on(0, 8000, n);
         range("second backoff", 8, mx * 2048 + 30, n);
         coll_n <= 2'd0;
         idle();
      end
      $display("test backoff limit finished");
   endtask

   initial
   begin
      sys_rst        = 1'b1;
      reg_wr         = 1'b0;
      reg_rd         = 1'b0;
      reg_addr       = 8'h00;
      reg_wdata      = 32'h0000_0000;
      tx_frame_ready = 1'b0;
      ee_present     = 1'b0;
      busy           = 1'b0;
      rx_on          = 1'b0;
      coll_n         = 2'd0;
      t_preload();
      t_defaults();
      t_transmit_enable();
      t_rx();
      t_abort();
      t_nolimit();
      t_restart();
      t_backoff();
      complete_run();
   end
endmodule
